//--- verilog/uco_pkg.sv
// Constants and types shared by the serial option block
package uco_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h10;
  localparam logic [7:0] ADDR_CTRL_THR = 8'h14;
  localparam logic [7:0] ADDR_GUARD_TIME_AND_DIVIDER     = 8'h18;
  localparam logic [7:0] ADDR_RECEIVE_TIMEOUT_VALUE     = 8'h1c;
  localparam logic [7:0] ADDR_FLAG_CLR = 8'h20;
  localparam logic [7:0] ADDR_LINE_CFG = 8'h24;
  // Writable bits of each register, reserved bits read zero
  localparam logic [31:0] MASK_CTRL_TWO = 32'hf00f_ff7f;
  localparam logic [31:0] MASK_CTRL_THR = 32'h0000_c7ff;
  localparam logic [31:0] MASK_GUARD_TIME_AND_DIVIDER     = 32'h0000_ffff;
  localparam logic [31:0] MASK_RECEIVE_TIMEOUT_VALUE     = 32'h00ff_ffff;
  localparam logic [31:0] MASK_LINE_CFG = 32'h0000_001f;
  localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
  // Control two field positions
  localparam int ID_HIGH_MSB = 31;
  localparam int ID_HIGH_LSB = 28;
  localparam int MSB_FIRST   = 19;
  localparam int DATA_INV    = 18;
  localparam int TX_INV      = 17;
  localparam int RX_INV      = 16;
  localparam int PIN_SWAP    = 15;
  localparam int LIN_EN      = 14;
  localparam int STOP_MSB    = 13;
  localparam int STOP_LSB    = 12;
  localparam int CLK_OUT_EN  = 11;
  localparam int CLK_IDLE    = 10;
  localparam int CLK_PHASE   = 9;
  localparam int LAST_PULSE  = 8;
  localparam int BREAK_IRQ   = 6;
  localparam int BREAK_LEN   = 5;
  localparam int ID_WIDTH    = 4;
  localparam int ID_LOW_MSB  = 3;
  localparam int ID_LOW_LSB  = 0;
  // Control three field positions
  localparam int DE_POL      = 15;
  localparam int RS485_EN    = 14;
  localparam int CTS_IRQ     = 10;
  localparam int CTS_FLOW    = 9;
  localparam int RTS_FLOW    = 8;
  localparam int TX_DMA      = 7;
  localparam int RX_DMA      = 6;
  localparam int SC_EN       = 5;
  localparam int SC_NACK     = 4;
  localparam int HALF_DUPLEX = 3;
  localparam int IRDA_LP     = 2;
  localparam int IRDA_EN     = 1;
  localparam int ERR_IRQ     = 0;
  // Guard time and divider fields
  localparam int GUARD_MSB   = 15;
  localparam int GUARD_LSB   = 8;
  localparam int DIV_MSB     = 7;
  localparam int DIV_LSB     = 0;
  localparam int CARD_DIV_MSB = 4;
  // Status and flag clear positions
  localparam int MATCH_BIT   = 17;
  localparam int TIMEOUT_BIT = 11;
  // Line configuration: data bits, parity, timeout enable, tx enable
  localparam int DBITS_MSB   = 1;
  localparam int DBITS_LSB   = 0;
  localparam int PARITY_EN   = 2;
  localparam int TIMEOUT_EN  = 3;
  localparam int TX_ENABLE   = 4;
  // Data bit count codes
  localparam logic [1:0] DBITS_8 = 2'h0;
  localparam logic [1:0] DBITS_9 = 2'h1;
  localparam logic [1:0] DBITS_7 = 2'h2;
  // Break frame lengths
  localparam logic [3:0] BREAK_SHORT = 4'ha;
  localparam logic [3:0] BREAK_LONG  = 4'hb;
  // Guard timer states
  typedef enum logic [0:0] {GUARD_IDLE, GUARD_WAIT} uco_guard_type;
endpackage

//--- verilog/uco_divider.sv
// Programmable clock divider giving a tick and a square wave
`timescale 1ns/1ps
`default_nettype none
module uco_divider #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESET,
  // Control
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] divide,
  // Outputs
  output logic                  tick,
  output logic                  square
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
    logic             square;
  } uco_div_state_type;

  uco_div_state_type state;
  uco_div_state_type next_state;

  // A zero divide is reserved, so the divider stops with count and square cleared
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (!enable || divide == '0) begin
      next_state.count = '0;
      next_state.square = 1'b0;
    end else if (state.count >= divide - 1'b1) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
      next_state.square = ~state.square;
    end else begin
      next_state.count = state.count + 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
  assign square = state.square;
endmodule
`default_nettype wire

//--- verilog/uco_top.sv
// Option and configuration logic of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module uco_top #(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET,
  // Avalon-MM slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Shifter side events and levels
  input  wire logic        BIT_TICK,
  input  wire logic        RX_BUSY,
  input  wire logic        RX_CHAR_VALID,
  input  wire logic [8:0]  RX_CHAR_RAW,
  input  wire logic        RX_PARITY_ERR,
  input  wire logic        FRAME_ERR,
  input  wire logic        OVERFLOW_ERR,
  input  wire logic        NOISE_ERR,
  input  wire logic [8:0]  TX_WORD,
  input  wire logic        TX_LINE_BIT,
  input  wire logic        TX_DONE_RAW,
  input  wire logic        TX_BUF_EMPTY,
  input  wire logic        RX_BUF_FULL,
  input  wire logic        TX_ACTIVE,
  input  wire logic        RTS_REQUEST,
  input  wire logic        SYNC_CLK_RUN,
  input  wire logic        SYNC_CLK_RAW,
  input  wire logic        SYNC_LAST_BIT,
  // Shifter side results
  output logic [8:0]       RX_DATA,
  output logic             RX_LINE_BIT,
  output logic [8:0]       TX_SHIFT_WORD,
  output logic [1:0]       STOP_BITS,
  output logic [3:0]       BREAK_BITS,
  output logic             CAPTURE_SECOND_EDGE,
  output logic             TX_COMPLETE,
  output logic             NACK_REQUEST,
  output logic             ERROR_IRQ,
  output logic             TX_DMA_REQ,
  output logic             RX_DMA_REQ,
  output logic             IRDA_TICK,
  // Serial pins
  input  wire logic        PIN_A_IN,
  output logic             PIN_A_OUT,
  output logic             PIN_A_OE,
  input  wire logic        PIN_B_IN,
  output logic             PIN_B_OUT,
  output logic             PIN_B_OE,
  output logic             CK_OUT,
  output logic             CK_OE,
  output logic             RTS_PIN
);
  typedef struct packed {
    logic [31:0]                ctrl_two;
    logic [31:0]                ctrl_thr;
    logic [31:0]                guard_time_and_divider;
    logic [31:0]                receive_timeout_value;
    logic [31:0]                line_cfg;
    logic                       match_flag;
    logic                       timeout_flag;
    logic                       timeout_armed;
    logic [23:0]                silent_count;
    uco_pkg::uco_guard_type     guard_state;
    logic [7:0]                 guard_count;
    logic                       ack;
    logic                       waitreq;
    logic [31:0]                readdata;
    logic [8:0]                 rx_data;
    logic [8:0]                 tx_word;
    logic                       rx_line;
    logic                       pin_a_out;
    logic                       pin_a_oe;
    logic                       pin_b_out;
    logic                       pin_b_oe;
    logic                       ck_out;
    logic                       ck_oe;
    logic                       rts_pin;
    logic                       tx_complete;
    logic                       nack;
    logic                       err_irq;
    logic                       tx_dma;
    logic                       rx_dma;
  } uco_state_type;

  uco_state_type state;
  uco_state_type next_state;

  logic card_tick;
  logic card_square;
  logic irda_tick;

  // Merge a write under byte enables into the writable bits
  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] be,
      input logic [31:0] mask);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return result & mask;
  endfunction

  // Reverse the low n bits of a character, upper bits stay zero
  function automatic logic [8:0] reverse_bits(input logic [8:0] value,
      input int n);
    logic [8:0] result;
    result = '0;
    for (int i = 0; i < 9; i++) begin
      if (i < n) begin
        result[i] = value[n - 1 - i];
      end
    end
    return result;
  endfunction

  // Decoded configuration
  logic [7:0] node_id;
  logic [1:0] data_bits;
  logic       parity_on;
  int         char_len;
  logic [7:0] id_mask;
  logic       smartcard;
  logic       swap;
  logic [8:0] rx_oriented;
  logic [8:0] tx_oriented;
  logic       rx_pin_level;
  logic       tx_pin_level;
  logic       sync_pulse_ok;
  logic [31:0] read_value;
  logic       wr_take;
  logic       rd_take;

  assign node_id = {state.ctrl_two[uco_pkg::ID_HIGH_MSB:uco_pkg::ID_HIGH_LSB],
                    state.ctrl_two[uco_pkg::ID_LOW_MSB:uco_pkg::ID_LOW_LSB]};
  assign data_bits = state.line_cfg[uco_pkg::DBITS_MSB:uco_pkg::DBITS_LSB];
  assign parity_on = state.line_cfg[uco_pkg::PARITY_EN];
  assign smartcard = state.ctrl_thr[uco_pkg::SC_EN];
  assign swap = state.ctrl_two[uco_pkg::PIN_SWAP];
  assign wr_take = AVS_WRITE && state.ack;
  assign rd_take = AVS_READ && state.ack;

  // Character length and id compare width follow the data format
  always_comb begin
    unique case (data_bits)
      uco_pkg::DBITS_7: char_len = 7;
      uco_pkg::DBITS_9: char_len = 9;
      default:          char_len = 8;
    endcase
    if (!state.ctrl_two[uco_pkg::ID_WIDTH]) begin
      id_mask = 8'h0f;
    end else begin
      id_mask = 8'(9'h1ff >> (10 - char_len + (parity_on ? 1 : 0)));
    end
  end

  // Bit order and data sense; the shifter always moves lsb first
  always_comb begin
    rx_oriented = state.ctrl_two[uco_pkg::MSB_FIRST]
                ? reverse_bits(RX_CHAR_RAW, char_len) : RX_CHAR_RAW;
    tx_oriented = state.ctrl_two[uco_pkg::MSB_FIRST]
                ? reverse_bits(TX_WORD, char_len) : TX_WORD;
    if (state.ctrl_two[uco_pkg::DATA_INV]) begin
      rx_oriented = ~rx_oriented & (9'h1ff >> (9 - char_len));
      tx_oriented = ~tx_oriented & (9'h1ff >> (9 - char_len));
    end
  end

  // Pin levels: swap picks the wires, inversion flips idle and mark
  assign rx_pin_level = (swap ? PIN_A_IN : PIN_B_IN)
                      ^ state.ctrl_two[uco_pkg::RX_INV];
  assign tx_pin_level = TX_LINE_BIT ^ state.ctrl_two[uco_pkg::TX_INV];

  // The last data bit clock is suppressed unless asked for
  assign sync_pulse_ok = !SYNC_LAST_BIT
                       || state.ctrl_two[uco_pkg::LAST_PULSE];

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    unique case (AVS_ADDRESS)
      uco_pkg::ADDR_STATUS:   read_value = 32'(
                                {state.match_flag, 5'h00, state.timeout_flag}
                                << uco_pkg::TIMEOUT_BIT);
      uco_pkg::ADDR_CTRL_TWO: read_value = state.ctrl_two;
      uco_pkg::ADDR_CTRL_THR: read_value = state.ctrl_thr;
      uco_pkg::ADDR_GUARD_TIME_AND_DIVIDER:     read_value = state.guard_time_and_divider;
      uco_pkg::ADDR_RECEIVE_TIMEOUT_VALUE:     read_value = state.receive_timeout_value;
      uco_pkg::ADDR_LINE_CFG: read_value = state.line_cfg;
      default:                read_value = 32'h0000_0000;
    endcase
  end

  // Next state of all registers
  always_comb begin
    next_state = state;
    // One wait state per access: waitrequest drops the cycle after
    next_state.ack = (AVS_READ || AVS_WRITE) && !state.ack;
    next_state.waitreq = !next_state.ack;
    if (next_state.ack && AVS_READ) begin
      next_state.readdata = read_value;
    end
    if (wr_take) begin
      unique case (AVS_ADDRESS)
        uco_pkg::ADDR_CTRL_TWO: next_state.ctrl_two = merge_bytes(
            state.ctrl_two, AVS_WRITEDATA, AVS_BYTEENABLE,
            uco_pkg::MASK_CTRL_TWO);
        uco_pkg::ADDR_CTRL_THR: next_state.ctrl_thr = merge_bytes(
            state.ctrl_thr, AVS_WRITEDATA, AVS_BYTEENABLE,
            uco_pkg::MASK_CTRL_THR);
        uco_pkg::ADDR_GUARD_TIME_AND_DIVIDER:     next_state.guard_time_and_divider = merge_bytes(
            state.guard_time_and_divider, AVS_WRITEDATA, AVS_BYTEENABLE, uco_pkg::MASK_GUARD_TIME_AND_DIVIDER);
        uco_pkg::ADDR_RECEIVE_TIMEOUT_VALUE:     next_state.receive_timeout_value = merge_bytes(
            state.receive_timeout_value, AVS_WRITEDATA, AVS_BYTEENABLE, uco_pkg::MASK_RECEIVE_TIMEOUT_VALUE);
        uco_pkg::ADDR_LINE_CFG: next_state.line_cfg = merge_bytes(
            state.line_cfg, AVS_WRITEDATA, AVS_BYTEENABLE,
            uco_pkg::MASK_LINE_CFG);
        default: ;
      endcase
    end

    // Flag clears first so that a same-cycle set still wins
    if (wr_take && AVS_ADDRESS == uco_pkg::ADDR_FLAG_CLR) begin
      if (AVS_BYTEENABLE[2] && AVS_WRITEDATA[uco_pkg::MATCH_BIT]) begin
        next_state.match_flag = 1'b0;
      end
      if (AVS_BYTEENABLE[1] && AVS_WRITEDATA[uco_pkg::TIMEOUT_BIT]) begin
        next_state.timeout_flag = 1'b0;
      end
    end

    // Character match against the masked node id
    if (RX_CHAR_VALID && ((rx_oriented[7:0] ^ node_id) & id_mask) == 8'h00) begin
      next_state.match_flag = 1'b1;
    end

    // Silence counted in bit periods; restarted by any traffic, rearmed only by a received character
    if (!state.line_cfg[uco_pkg::TIMEOUT_EN] || RX_BUSY || RX_CHAR_VALID) begin
      next_state.silent_count = '0;
      next_state.timeout_armed = RX_CHAR_VALID || state.timeout_armed;
    end else if (BIT_TICK && state.timeout_armed) begin
      next_state.silent_count = state.silent_count + 1'b1;
      if (state.silent_count + 1'b1 >= state.receive_timeout_value[23:0]) begin
        next_state.timeout_flag = 1'b1;
        next_state.timeout_armed = 1'b0;
      end
    end

    // Transmit complete, held back by the guard time on a card
    next_state.tx_complete = 1'b0;
    unique case (state.guard_state)
      uco_pkg::GUARD_IDLE: begin
        if (TX_DONE_RAW) begin
          if (smartcard && state.guard_time_and_divider[uco_pkg::GUARD_MSB:uco_pkg::GUARD_LSB]
              != 8'h00) begin
            next_state.guard_state = uco_pkg::GUARD_WAIT;
            next_state.guard_count = 8'h00;
          end else begin
            next_state.tx_complete = 1'b1;
          end
        end
      end
      uco_pkg::GUARD_WAIT: begin
        if (BIT_TICK) begin
          next_state.guard_count = state.guard_count + 1'b1;
          if (state.guard_count + 1'b1
              >= state.guard_time_and_divider[uco_pkg::GUARD_MSB:uco_pkg::GUARD_LSB]) begin
            next_state.tx_complete = 1'b1;
            next_state.guard_state = uco_pkg::GUARD_IDLE;
          end
        end
      end
    endcase

    // Registered datapath and pin outputs
    if (RX_CHAR_VALID) begin
      next_state.rx_data = rx_oriented;
    end
    next_state.tx_word = tx_oriented;
    next_state.rx_line = rx_pin_level;
    next_state.pin_a_out = swap ? 1'b1 : tx_pin_level;
    next_state.pin_a_oe = !swap;
    next_state.pin_b_out = swap ? tx_pin_level : 1'b1;
    next_state.pin_b_oe = swap;

    // Clock pin: card clock on a smartcard, shifter clock otherwise
    next_state.ck_oe = state.ctrl_two[uco_pkg::CLK_OUT_EN];
    if (!state.ctrl_two[uco_pkg::CLK_OUT_EN]) begin
      next_state.ck_out = 1'b0;
    end else if (smartcard) begin
      next_state.ck_out = card_square;
    end else if (SYNC_CLK_RUN && sync_pulse_ok) begin
      next_state.ck_out = SYNC_CLK_RAW ^ state.ctrl_two[uco_pkg::CLK_IDLE];
    end else begin
      next_state.ck_out = state.ctrl_two[uco_pkg::CLK_IDLE];
    end

    // Direction control shares the request-to-send pin
    if (state.ctrl_thr[uco_pkg::RS485_EN]) begin
      next_state.rts_pin = TX_ACTIVE
                         ^ state.ctrl_thr[uco_pkg::DE_POL];
    end else begin
      next_state.rts_pin = RTS_REQUEST;
    end

    next_state.nack = RX_CHAR_VALID && RX_PARITY_ERR && smartcard
                    && state.ctrl_thr[uco_pkg::SC_NACK];
    next_state.err_irq = state.ctrl_thr[uco_pkg::ERR_IRQ]
                       && (FRAME_ERR || OVERFLOW_ERR || NOISE_ERR);
    next_state.tx_dma = state.ctrl_thr[uco_pkg::TX_DMA] && TX_BUF_EMPTY;
    next_state.rx_dma = state.ctrl_thr[uco_pkg::RX_DMA] && RX_BUF_FULL;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state <= '0;
      state.waitreq <= 1'b1;
      state.rx_line <= 1'b1;
      state.pin_a_out <= 1'b1;
      state.pin_a_oe <= 1'b1;
      state.pin_b_out <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Card clock toggles every divider count, a period of twice that
  uco_divider #(
    .WIDTH(5)
  ) u_card_clock (
    .MCLK   (MCLK),
    .RESET  (RESET),
    .enable (smartcard),
    .divide (state.guard_time_and_divider[uco_pkg::CARD_DIV_MSB:uco_pkg::DIV_LSB]),
    .tick   (card_tick),
    .square (card_square)
  );

  // IrDA low power pulse time base; zero is reserved and stalls it
  uco_divider #(
    .WIDTH(DIV_WIDTH)
  ) u_irda_base (
    .MCLK   (MCLK),
    .RESET  (RESET),
    .enable (state.ctrl_thr[uco_pkg::IRDA_EN]
             && state.ctrl_thr[uco_pkg::IRDA_LP]),
    .divide (state.guard_time_and_divider[DIV_WIDTH-1:0]),
    .tick   (irda_tick),
    .square ()
  );

  // Outputs straight from flip-flops; config fields are register bits
  assign AVS_READDATA = state.readdata;
  assign AVS_WAITREQUEST = state.waitreq;
  assign RX_DATA = state.rx_data;
  assign RX_LINE_BIT = state.rx_line;
  assign TX_SHIFT_WORD = state.tx_word;
  assign STOP_BITS = state.ctrl_two[uco_pkg::STOP_MSB:uco_pkg::STOP_LSB];
  assign BREAK_BITS = state.ctrl_two[uco_pkg::BREAK_LEN]
                    ? uco_pkg::BREAK_LONG : uco_pkg::BREAK_SHORT;
  assign CAPTURE_SECOND_EDGE = state.ctrl_two[uco_pkg::CLK_PHASE];
  assign TX_COMPLETE = state.tx_complete;
  assign NACK_REQUEST = state.nack;
  assign ERROR_IRQ = state.err_irq;
  assign TX_DMA_REQ = state.tx_dma;
  assign RX_DMA_REQ = state.rx_dma;
  assign IRDA_TICK = irda_tick;
  assign PIN_A_OUT = state.pin_a_out;
  assign PIN_A_OE = state.pin_a_oe;
  assign PIN_B_OUT = state.pin_b_out;
  assign PIN_B_OE = state.pin_b_oe;
  assign CK_OUT = state.ck_out;
  assign CK_OE = state.ck_oe;
  assign RTS_PIN = state.rts_pin;
endmodule
`default_nettype wire

//--- tb/uco_monitor.sv
// Port checker for the serial option block, bound to its top
`timescale 1ns/1ps
`default_nettype none
module uco_monitor (
  // Clock, reset and bus handshake
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Shifter events and results
  input wire logic FRAME_ERR,
  input wire logic OVERFLOW_ERR,
  input wire logic NOISE_ERR,
  input wire logic ERROR_IRQ,
  input wire logic TX_BUF_EMPTY,
  input wire logic RX_BUF_FULL,
  input wire logic TX_DMA_REQ,
  input wire logic RX_DMA_REQ,
  input wire logic RX_CHAR_VALID,
  input wire logic RX_PARITY_ERR,
  input wire logic NACK_REQUEST,
  input wire logic TX_DONE_RAW,
  input wire logic BIT_TICK,
  input wire logic TX_COMPLETE,
  // Serial pin enables
  input wire logic PIN_A_OE,
  input wire logic PIN_B_OE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // Acknowledge lasts exactly one cycle
  sequence s_ack;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  a_ack_single: assert property ($fell(AVS_WAITREQUEST) |-> s_ack)
    else $error("acknowledge held too long");
  a_ack_cause: assert property (!AVS_WAITREQUEST |->
    $past(AVS_READ || AVS_WRITE)) else $error("acknowledge without request");
  a_err_gate: assert property (
    ERROR_IRQ |-> $past(FRAME_ERR || OVERFLOW_ERR || NOISE_ERR))
    else $error("error interrupt without error");
  a_txdma_gate: assert property (
    TX_DMA_REQ |-> $past(TX_BUF_EMPTY)) else $error("stray tx request");
  a_rxdma_gate: assert property (
    RX_DMA_REQ |-> $past(RX_BUF_FULL)) else $error("stray rx request");
  a_nack_cause: assert property (
    NACK_REQUEST |-> $past(RX_CHAR_VALID && RX_PARITY_ERR))
    else $error("nack without parity error");
  a_pin_drive: assert property (
    !(PIN_A_OE && PIN_B_OE)) else $error("both pins driven");
  a_done_cause: assert property (
    TX_COMPLETE |-> $past(TX_DONE_RAW || BIT_TICK))
    else $error("complete without frame end or tick");
endmodule
bind uco_top uco_monitor mon (.*);
`default_nettype wire

//--- tb/uco_peer.sv
// Far-side serial peer: holds the pulled-up line idle or low
`timescale 1ns/1ps
`default_nettype none
module uco_peer (
  // Device pins
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  // Bench command
  input  wire logic hold_low,
  // Wire levels
  output logic      a_in,
  output logic      b_in
);
  // A pin the device drives wins; otherwise the peer sets it
  assign a_in = a_oe ? a_out : !hold_low;
  assign b_in = b_oe ? b_out : !hold_low;
endmodule
`default_nettype wire

//--- tb/uco_top_bench.sv
// Self-checking bench for the serial option block
`timescale 1ns/1ps
`default_nettype none
module uco_top_bench;
  logic MCLK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, hold_low;
  logic [7:0] AVS_ADDRESS;
  logic [3:0] AVS_BYTEENABLE, BREAK_BITS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rdata;
  logic BIT_TICK, RX_BUSY, RX_CHAR_VALID, RX_PARITY_ERR, FRAME_ERR;
  logic OVERFLOW_ERR, NOISE_ERR, TX_LINE_BIT, TX_DONE_RAW, TX_BUF_EMPTY;
  logic RX_BUF_FULL, TX_ACTIVE, RTS_REQUEST, SYNC_CLK_RUN, SYNC_CLK_RAW;
  logic SYNC_LAST_BIT, RX_LINE_BIT, CAPTURE_SECOND_EDGE, TX_COMPLETE;
  logic NACK_REQUEST, ERROR_IRQ, TX_DMA_REQ, RX_DMA_REQ, IRDA_TICK;
  logic [8:0] RX_CHAR_RAW, TX_WORD, RX_DATA, TX_SHIFT_WORD;
  logic [1:0] STOP_BITS;
  logic PIN_A_IN, PIN_A_OUT, PIN_A_OE, PIN_B_IN, PIN_B_OUT, PIN_B_OE;
  logic CK_OUT, CK_OE, RTS_PIN;
  int num_errors, check_count, cyc;
  logic [7:0] adr [7] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h24, 8'h00, 8'h30};
  logic [31:0] msk [7] = '{uco_pkg::MASK_CTRL_TWO, uco_pkg::MASK_CTRL_THR,
    uco_pkg::MASK_GUARD_TIME_AND_DIVIDER, uco_pkg::MASK_RECEIVE_TIMEOUT_VALUE, uco_pkg::MASK_LINE_CFG,
    32'h0, 32'h0};
  // Static outputs gathered so one compare covers a setting
  wire logic [15:0] obs = {CK_OE, CK_OUT, PIN_A_OUT, PIN_A_OE, NACK_REQUEST,
    PIN_B_OE, ERROR_IRQ, TX_DMA_REQ, RX_DMA_REQ, CAPTURE_SECOND_EDGE,
    STOP_BITS, BREAK_BITS};
  uco_top dut (.*);
  uco_peer peer (.a_out(PIN_A_OUT), .a_oe(PIN_A_OE), .b_out(PIN_B_OUT),
    .b_oe(PIN_B_OE), .hold_low(hold_low), .a_in(PIN_A_IN), .b_in(PIN_B_IN));
  initial begin
    MCLK = 1'b0;
    forever #25 MCLK = ~MCLK;
  end
  // Watchdog: the run needs well under a thousand cycles
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus access held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be);
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    // Only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge MCLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    rdata = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    acc(1'b0, a, 32'h0, 4'hf);
  endtask
  // Write a setting, let it settle, compare the gathered outputs
  task automatic cfg(input logic [7:0] a, input logic [31:0] d,
      input logic [15:0] e);
    wr(a, d);
    repeat (3) @(posedge MCLK);
    #1;
    chk(obs, e);
  endtask
  task automatic rx(input logic [8:0] v, input logic pe);
    @(posedge MCLK);
    RX_CHAR_RAW <= v;
    RX_PARITY_ERR <= pe;
    RX_CHAR_VALID <= 1'b1;
    @(posedge MCLK);
    RX_CHAR_VALID <= 1'b0;
    #1;
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge MCLK);
      BIT_TICK <= 1'b1;
      @(posedge MCLK);
      BIT_TICK <= 1'b0;
    end
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {AVS_READ, AVS_WRITE, BIT_TICK, RX_BUSY, RX_CHAR_VALID} = '0;
    {RX_PARITY_ERR, OVERFLOW_ERR, NOISE_ERR, TX_DONE_RAW, RTS_REQUEST} = '0;
    {SYNC_CLK_RUN, SYNC_CLK_RAW, SYNC_LAST_BIT, hold_low} = '0;
    {FRAME_ERR, TX_LINE_BIT, TX_BUF_EMPTY, RX_BUF_FULL, TX_ACTIVE} = '1;
    {AVS_ADDRESS, AVS_WRITEDATA, RX_CHAR_RAW} = '0;
    AVS_BYTEENABLE = 4'hf;
    TX_WORD = 9'h025;
    RESET = 1'b1;
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    // Reset values, writable bits, then a single byte-lane write
    for (int i = 0; i < 7; i++) begin
      rd(adr[i]);
      chk(rdata, 32'h0);
      wr(adr[i], 32'hffff_ffff);
      rd(adr[i]);
      chk(rdata, msk[i]);
      wr(adr[i], 32'h0);
    end
    acc(1'b1, 8'h1c, 32'hffff_ffff, 4'h2);
    rd(8'h1c);
    chk(rdata, 32'h0000_ff00);
    wr(8'h1c, 32'h0);
    $display("registers done");
    for (int i = 0; i < 3; i++) begin
      @(posedge MCLK);
      {FRAME_ERR, OVERFLOW_ERR, NOISE_ERR} <= 3'h4 >> i;
      cfg(8'h14, 32'h1, 16'h320a);
      cfg(8'h14, 32'h0, 16'h300a);
    end
    cfg(8'h14, 32'h80, 16'h310a);
    cfg(8'h14, 32'h40, 16'h308a);
    chk(RTS_PIN, 1'b0);
    cfg(8'h14, 32'h4000, 16'h300a);
    chk(RTS_PIN, 1'b1);
    cfg(8'h14, 32'hc000, 16'h300a);
    chk(RTS_PIN, 1'b0);
    @(posedge MCLK);
    TX_ACTIVE <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
    chk(RTS_PIN, 1'b1);
    for (int i = 0; i < 4; i++) begin
      cfg(8'h10, {18'h0, 2'(i), 12'h0}, {8'h30, 2'h0, 2'(i), 4'ha});
    end
    cfg(8'h10, 32'h0000_0020, 16'h300b);
    cfg(8'h10, 32'h0000_0200, 16'h304a);
    cfg(8'h10, 32'h0000_0800, 16'hb00a);
    cfg(8'h10, 32'h0000_0c00, 16'hf00a);
    // Shifter clock high on its last bit: shown only with the pulse bit
    @(posedge MCLK);
    {SYNC_CLK_RUN, SYNC_CLK_RAW, SYNC_LAST_BIT} <= 3'h7;
    cfg(8'h10, 32'h0000_0800, 16'hb00a);
    cfg(8'h10, 32'h0000_0900, 16'hf00a);
    cfg(8'h10, 32'h0002_0000, 16'h100a);
    chk(RX_LINE_BIT, 1'b1);
    @(posedge MCLK);
    hold_low <= 1'b1;
    cfg(8'h10, 32'h0000_8000, 16'h240a);
    chk(RX_LINE_BIT, 1'b0);
    cfg(8'h10, 32'h0003_8000, 16'h240a);
    chk(RX_LINE_BIT, 1'b1);
    chk(PIN_B_OUT, 1'b0);
    @(posedge MCLK);
    hold_low <= 1'b0;
    $display("options done");
    // Seven-bit compare: 0x25 matches id 0xa5, 0x26 does not
    wr(8'h10, 32'ha000_0015);
    rx(9'h026, 1'b0);
    chk(RX_DATA, 9'h026);
    rd(8'h00);
    chk(rdata, 32'h0);
    rx(9'h025, 1'b0);
    rd(8'h00);
    chk(rdata, 32'h0002_0000);
    wr(8'h20, 32'h0);
    rd(8'h00);
    chk(rdata, 32'h0002_0000);
    wr(8'h20, 32'h0002_0000);
    rd(8'h00);
    chk(rdata, 32'h0);
    wr(8'h10, 32'h000c_0000);
    rx(9'h025, 1'b0);
    chk(RX_DATA, 9'h05b);
    chk(TX_SHIFT_WORD, 9'h05b);
    $display("receive done");
    wr(8'h1c, 32'h3);
    wr(8'h24, 32'h8);
    rx(9'h025, 1'b0);
    tick(2);
    rd(8'h00);
    chk(rdata[11], 1'b0);
    tick(3);
    rd(8'h00);
    chk(rdata[11], 1'b1);
    wr(8'h20, 32'h800);
    rd(8'h00);
    chk(rdata[11], 1'b0);
    $display("timeout done");
    wr(8'h14, 32'h20);
    rx(9'h025, 1'b1);
    chk(NACK_REQUEST, 1'b0);
    wr(8'h14, 32'h30);
    rx(9'h025, 1'b1);
    chk(NACK_REQUEST, 1'b1);
    wr(8'h18, 32'h0200);
    @(posedge MCLK);
    TX_DONE_RAW <= 1'b1;
    @(posedge MCLK);
    TX_DONE_RAW <= 1'b0;
    tick(1);
    chk(TX_COMPLETE, 1'b0);
    tick(1);
    chk(TX_COMPLETE, 1'b1);
    // Divider of one: IrDA tick every cycle, card clock toggles each cycle
    wr(8'h14, 32'h26);
    wr(8'h18, 32'h1);
    wr(8'h10, 32'h800);
    repeat (2) @(posedge MCLK);
    #1;
    chk(IRDA_TICK, 1'b1);
    rdata[0] = CK_OUT;
    @(posedge MCLK);
    #1;
    chk(CK_OUT, !rdata[0]);
    $display("smartcard done");
    report_and_stop();
  end
endmodule
`default_nettype wire
